// ### verilog/tpc_ctrl.sv
// Notes on behaviour
// - pwm two enabled: port b bit 3 driven by pwm two, direction ignored
// - pwm two disabled: pwm two inactive, bit 3 follows its direction bit
// - pwm one enabled: port b bit 2 driven by pwm one, direction ignored
// - pwm one disabled: pwm one inactive, bit 2 follows its direction bit
// - capture one overrun reads zero unless an event hit an unread value
// - event before both bytes read sets overrun, keeps old value, blocks
// - wide select chains timer two above timer one, else two 8-bit timers
// - timer three pair is period register or capture one, by select bit
`timescale 1ns/1ns
`include "tpc_regs.svh"

module tpc_ctrl #(
    parameter int ADDR_W = 8
) (
    // clock and reset
    input  wire logic              core_clk,
    input  wire logic              sys_rst,
    // avalon-mm slave
    input  wire logic [ADDR_W-1:0] avs_address,
    input  wire logic              avs_read,
    input  wire logic              avs_write,
    input  wire logic [31:0]       avs_writedata,
    input  wire logic [3:0]        avs_byteenable,
    output logic      [31:0]       avs_readdata,
    output logic                   avs_waitrequest,
    // timer datapath
    input  wire logic              timer_tick,
    input  wire logic              timer_one_carry,
    input  wire tpc_pkg::tpc_word_t timer_three_count,
    input  wire logic [1:0]        capture_event,
    // pwm and port b
    input  wire logic [1:0]        pwm_level,
    input  wire logic [1:0]        portb_direction_register,
    input  wire logic [1:0]        portb_data,
    output tpc_pkg::tpc_pin_t      portb_bit2_pwm_one_pin,
    output tpc_pkg::tpc_pin_t      portb_bit3_pwm_two_pin,
    output logic                   pwm_one_enable,
    output logic                   pwm_two_enable,
    // timer control
    output tpc_pkg::tpc_run_t      timer_run,
    output tpc_pkg::tpc_run_t      timer_inc,
    output logic                   timer_pair_wide_select,
    output logic                   period_active,
    output tpc_pkg::tpc_word_t     period_value
);
    import tpc_pkg::*;

    // ****************************************
    // decode helper
    // ****************************************

    // word index match, low address bits ignored
    function automatic logic hit(
        input logic [ADDR_W-1:0] addr,
        input logic [5:0]        idx
    );
        hit = (addr[7:2] == idx);
    endfunction

    // ****************************************
    // bus handshake
    // ****************************************

    logic       ack_q;
    logic       req;
    logic       acc;
    logic       rd_acc;
    logic       wr_acc;
    logic [7:0] wr_byte;

    // one wait cycle, taken on the second edge
    assign req             = avs_read | avs_write;
    assign avs_waitrequest = req & ~ack_q;
    assign acc             = req & ack_q;
    assign rd_acc          = acc & avs_read;
    assign wr_acc          = acc & avs_write & avs_byteenable[0];
    assign wr_byte         = avs_writedata[7:0];

    // ack toggles once per request
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= req & ~ack_q;
        end
    end

    // ****************************************
    // address decode
    // ****************************************

    logic hit_c1;
    logic hit_c2;
    logic wr_c1;
    logic wr_c2;

    // control register selects
    assign hit_c1 = hit(avs_address, `TPC_IDX_CTRL_ONE);
    assign hit_c2 = hit(avs_address, `TPC_IDX_CTRL_TWO);
    assign wr_c1  = wr_acc & hit_c1;
    assign wr_c2  = wr_acc & hit_c2;

    // ****************************************
    // control registers
    // ****************************************

    logic [5:0] ctl_q;
    logic [5:0] ctl_d;
    logic       wide_q;
    logic       wide_d;

    localparam logic [7:0] CTRL_ONE_RST = `TPC_CTRL_ONE_RST;

    // only writable bits are stored, flags live per channel
    assign ctl_d  = wr_c2 ? wr_byte[5:0] : ctl_q;
    assign wide_d = wr_c1 ? wr_byte[`TPC_BIT_WIDE] : wide_q;

    // control state
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            ctl_q  <= 6'(`TPC_CTRL_TWO_RST & `TPC_CTRL_TWO_WM);
            wide_q <= CTRL_ONE_RST[`TPC_BIT_WIDE];
        end else begin
            ctl_q  <= ctl_d;
            wide_q <= wide_d;
        end
    end

    logic run1;
    logic run2;
    logic run3;
    logic cap_sel;
    logic pwm1_en;
    logic pwm2_en;

    // field extraction
    assign run1    = ctl_q[`TPC_BIT_T1_RUN];
    assign run2    = ctl_q[`TPC_BIT_T2_RUN];
    assign run3    = ctl_q[`TPC_BIT_T3_RUN];
    assign cap_sel = ctl_q[`TPC_BIT_CAP_SEL];
    assign pwm1_en = ctl_q[`TPC_BIT_PWM1_EN];
    assign pwm2_en = ctl_q[`TPC_BIT_PWM2_EN];

    // ****************************************
    // timer run control
    // ****************************************

    logic t1_go;
    logic t2_go;

    // upper half of the pair counts only with both run bits set, lower half with run one alone
    assign t1_go = run1 & timer_tick;
    assign t2_go = wide_q ? (t1_go & run2 & timer_one_carry)
                          : (run2 & timer_tick);

    // run levels and increment strobes
    assign timer_run.t1         = run1;
    assign timer_run.t2         = wide_q ? (run1 & run2) : run2;
    assign timer_run.t3         = run3;
    assign timer_inc.t1         = t1_go;
    assign timer_inc.t2         = t2_go;
    assign timer_inc.t3         = run3 & timer_tick;
    assign timer_pair_wide_select = wide_q;

    // ****************************************
    // capture channels
    // ****************************************

    logic [1:0][15:0] cap_q;
    logic [1:0]       full_q;
    logic [1:0]       lo_rd_q;
    logic [1:0]       hi_rd_q;
    logic [1:0]       ovf_q;
    logic [1:0]       rd_lo;
    logic [1:0]       rd_hi;
    logic [1:0]       wr_lo;
    logic [1:0]       wr_hi;
    logic [1:0]       both_rd;
    logic [1:0]       cap_en;
    logic [1:0]       load;
    logic [1:0]       ovf_set;

    genvar c;
    generate
        for (c = 0; c < 2; c++) begin : g_cap
            localparam logic [5:0] IDX_LO = 6'(`TPC_IDX_CAP1_LO + 2 * c);
            localparam logic [5:0] IDX_HI = 6'(`TPC_IDX_CAP1_HI + 2 * c);

            // channel one captures only in capture mode
            if (c == 0) begin : g_sel
                assign cap_en[c] = capture_event[c] & cap_sel;
            end else begin : g_any
                assign cap_en[c] = capture_event[c];
            end

            // byte access strobes
            assign rd_lo[c] = rd_acc & hit(avs_address, IDX_LO);
            assign rd_hi[c] = rd_acc & hit(avs_address, IDX_HI);
            assign wr_lo[c] = wr_acc & hit(avs_address, IDX_LO) & (c == 0) & ~cap_sel;
            assign wr_hi[c] = wr_acc & hit(avs_address, IDX_HI) & (c == 0) & ~cap_sel;

            // both bytes seen since last load
            assign both_rd[c] = (lo_rd_q[c] | rd_lo[c]) & (hi_rd_q[c] | rd_hi[c]);

            // load when free, otherwise overrun keeps old value
            assign load[c]    = cap_en[c] & (~full_q[c] | both_rd[c]);
            assign ovf_set[c] = cap_en[c] & full_q[c] & ~both_rd[c];

            // capture value
            always_ff @(posedge core_clk) begin
                if (sys_rst) begin
                    cap_q[c] <= `TPC_CAP_RST;
                end else if (load[c]) begin
                    cap_q[c] <= timer_three_count;
                end else if (wr_lo[c]) begin
                    cap_q[c][7:0] <= wr_byte;
                end else if (wr_hi[c]) begin
                    cap_q[c][15:8] <= wr_byte;
                end
            end

            // unread tracking and overrun flag, set wins
            always_ff @(posedge core_clk) begin
                if (sys_rst) begin
                    full_q[c]  <= 1'b0;
                    lo_rd_q[c] <= 1'b0;
                    hi_rd_q[c] <= 1'b0;
                    ovf_q[c]   <= 1'b0;
                end else begin
                    full_q[c]  <= load[c] | (full_q[c] & ~both_rd[c]);
                    lo_rd_q[c] <= ~load[c] & ~both_rd[c] & full_q[c] & (lo_rd_q[c] | rd_lo[c]);
                    hi_rd_q[c] <= ~load[c] & ~both_rd[c] & full_q[c] & (hi_rd_q[c] | rd_hi[c]);
                    ovf_q[c]   <= ovf_set[c] | (ovf_q[c] & ~both_rd[c]);
                end
            end
        end
    endgenerate

    // period register view of channel one
    assign period_active = ~cap_sel;
    assign period_value  = cap_q[0];

    // ****************************************
    // read mux
    // ****************************************

    logic [7:0] ctl2_rd;
    logic [7:0] ctl1_rd;
    logic [7:0] rd_mux;
    logic [5:0] rd_idx;

    // flags read through, reserved bits zero
    assign ctl2_rd = {ovf_q[1], ovf_q[0], ctl_q};
    assign ctl1_rd = {4'h0, wide_q, 3'h0};
    assign rd_idx  = avs_address[7:2];

    // unmapped addresses read zero
    always_comb begin
        unique case (rd_idx)
            `TPC_IDX_CTRL_ONE: rd_mux = ctl1_rd;
            `TPC_IDX_CTRL_TWO: rd_mux = ctl2_rd;
            `TPC_IDX_CAP1_LO:  rd_mux = cap_q[0][7:0];
            `TPC_IDX_CAP1_HI:  rd_mux = cap_q[0][15:8];
            `TPC_IDX_CAP2_LO:  rd_mux = cap_q[1][7:0];
            `TPC_IDX_CAP2_HI:  rd_mux = cap_q[1][15:8];
            default:           rd_mux = 8'h00;
        endcase
    end

    logic [7:0] rdata_q;

    // read data latched in the wait cycle
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            rdata_q <= 8'h00;
        end else if (avs_read & ~ack_q) begin
            rdata_q <= rd_mux;
        end
    end

    assign avs_readdata = {24'h000000, rdata_q};

    // ****************************************
    // pwm pin steering
    // ****************************************

    tpc_pin_t pin2_q;
    tpc_pin_t pin2_d;
    tpc_pin_t pin3_q;
    tpc_pin_t pin3_d;

    // enabled pwm owns the pin, else direction bit one means input
    assign pin2_d.out = pwm1_en ? pwm_level[0] : portb_data[0];
    assign pin2_d.oe  = pwm1_en | ~portb_direction_register[0];
    assign pin3_d.out = pwm2_en ? pwm_level[1] : portb_data[1];
    assign pin3_d.oe  = pwm2_en | ~portb_direction_register[1];

    // registered pin drive, released at reset
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            pin2_q <= '0;
            pin3_q <= '0;
        end else begin
            pin2_q <= pin2_d;
            pin3_q <= pin3_d;
        end
    end

    // pwm generators run only while enabled
    assign portb_bit2_pwm_one_pin = pin2_q;
    assign portb_bit3_pwm_two_pin = pin3_q;
    assign pwm_one_enable         = pwm1_en;
    assign pwm_two_enable         = pwm2_en;

endmodule

// ### verilog/tpc_regs.svh
`ifndef TPC_REGS_SVH
`define TPC_REGS_SVH

// register indices, byte address is four times the index
`define TPC_IDX_CTRL_ONE 6'h16
`define TPC_IDX_CTRL_TWO 6'h17
`define TPC_IDX_CAP1_LO  6'h18
`define TPC_IDX_CAP1_HI  6'h19
`define TPC_IDX_CAP2_LO  6'h1a
`define TPC_IDX_CAP2_HI  6'h1b

// control two field positions
`define TPC_BIT_T1_RUN   0
`define TPC_BIT_T2_RUN   1
`define TPC_BIT_T3_RUN   2
`define TPC_BIT_CAP_SEL  3
`define TPC_BIT_PWM1_EN  4
`define TPC_BIT_PWM2_EN  5
`define TPC_BIT_OVF1     6
`define TPC_BIT_OVF2     7

// control one field position
`define TPC_BIT_WIDE     3

// reset values and writable masks
`define TPC_CTRL_TWO_RST 8'h00
`define TPC_CTRL_TWO_WM  8'h3f
`define TPC_CTRL_ONE_RST 8'h00
`define TPC_CAP_RST      16'h0000

`endif

// ### verilog/tpc_pkg.sv
package tpc_pkg;

    // one pin with its output enable
    typedef struct packed {
        logic out;
        logic oe;
    } tpc_pin_t;

    // timer run and increment enables
    typedef struct packed {
        logic t3;
        logic t2;
        logic t1;
    } tpc_run_t;

    typedef logic [15:0] tpc_word_t;

endpackage

// ### testbench/tpc_ctrl_properties.sv
`timescale 1ns/1ns
// ****************
// pin, timer enable and capture hold checks
// ****************
module tpc_ctrl_chk (
    // clock and reset
    input wire logic              core_clk,
    input wire logic              sys_rst,
    // watched inputs
    input wire logic              avs_write,
    input wire logic              timer_tick,
    input wire logic              timer_one_carry,
    input wire logic [1:0]        capture_event,
    input wire logic [1:0]        pwm_level,
    input wire logic [1:0]        portb_direction_register,
    input wire logic [1:0]        portb_data,
    // watched outputs
    input wire tpc_pkg::tpc_pin_t portb_bit2_pwm_one_pin,
    input wire tpc_pkg::tpc_pin_t portb_bit3_pwm_two_pin,
    input wire logic              pwm_one_enable,
    input wire logic              pwm_two_enable,
    input wire tpc_pkg::tpc_run_t timer_run,
    input wire tpc_pkg::tpc_run_t timer_inc,
    input wire logic              timer_pair_wide_select,
    input wire tpc_pkg::tpc_word_t period_value
);
    import tpc_pkg::*;
    // one clock domain
    default clocking @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    property p_pwm2_on;
        pwm_two_enable |=> portb_bit3_pwm_two_pin == {$past(pwm_level[1]), 1'b1};
    endproperty
    a_pwm2_on: assert property (p_pwm2_on) else $error("pin3 not driven by pwm");
    property p_pwm2_off;
        !sys_rst && !pwm_two_enable |=>
            portb_bit3_pwm_two_pin == {$past(portb_data[1]), !$past(portb_direction_register[1])};
    endproperty
    a_pwm2_off: assert property (p_pwm2_off) else $error("pin3 ignores direction");
    property p_pwm1_on;
        pwm_one_enable |=> portb_bit2_pwm_one_pin == {$past(pwm_level[0]), 1'b1};
    endproperty
    a_pwm1_on: assert property (p_pwm1_on) else $error("pin2 not driven by pwm");
    property p_pwm1_off;
        !sys_rst && !pwm_one_enable |=>
            portb_bit2_pwm_one_pin == {$past(portb_data[0]), !$past(portb_direction_register[0])};
    endproperty
    a_pwm1_off: assert property (p_pwm1_off) else $error("pin2 ignores direction");
    property p_inc_single;
        timer_inc.t1 == (timer_run.t1 && timer_tick) && timer_inc.t3 == (timer_run.t3 && timer_tick);
    endproperty
    a_inc_single: assert property (p_inc_single) else $error("timer one or three step wrong");
    property p_inc_wide;
        timer_pair_wide_select |-> timer_inc.t2 == (timer_run.t1 && timer_run.t2 && timer_tick && timer_one_carry);
    endproperty
    a_inc_wide: assert property (p_inc_wide) else $error("chained upper step wrong");
    property p_inc_narrow;
        !timer_pair_wide_select |-> timer_inc.t2 == (timer_run.t2 && timer_tick);
    endproperty
    a_inc_narrow: assert property (p_inc_narrow) else $error("timer two step wrong");
    property p_cap_hold;
        !capture_event[0] && !avs_write |=> $stable(period_value);
    endproperty
    a_cap_hold: assert property (p_cap_hold) else $error("channel one value moved");
endmodule
bind tpc_ctrl tpc_ctrl_chk u_chk (.core_clk, .sys_rst, .avs_write, .timer_tick, .timer_one_carry,
    .capture_event, .pwm_level, .portb_direction_register, .portb_data, .portb_bit2_pwm_one_pin,
    .portb_bit3_pwm_two_pin, .pwm_one_enable, .pwm_two_enable, .timer_run, .timer_inc,
    .timer_pair_wide_select, .period_value);

// ### testbench/tb.sv
`timescale 1ns/1ns
`include "tpc_regs.svh"
module tb;
    import tpc_pkg::*;
    // ****************
    // stimulus and observed signals
    // ****************
    logic       core_clk = 1'b0;
    logic       sys_rst = 1'b1;
    logic [7:0] avs_address = 8'h00;
    logic       avs_read = 1'b0, avs_write = 1'b0, avs_waitrequest;
    logic [31:0] avs_writedata = 32'h0, avs_readdata;
    logic [3:0] avs_byteenable = 4'hf;
    logic       timer_tick = 1'b0, timer_one_carry = 1'b0;
    tpc_word_t  timer_three_count = 16'h0000, period_value;
    logic [1:0] capture_event = 2'h0, pwm_level = 2'h0, portb_direction_register = 2'h0, portb_data = 2'h0;
    tpc_pin_t   portb_bit2_pwm_one_pin, portb_bit3_pwm_two_pin;
    logic       pwm_one_enable, pwm_two_enable, timer_pair_wide_select, period_active;
    tpc_run_t   timer_run, timer_inc;
    int         fail_count = 0, num_checks = 0;
    // 100 mhz clock
    always #5 core_clk = ~core_clk;
    tpc_ctrl DUT (.core_clk, .sys_rst, .avs_address, .avs_read, .avs_write, .avs_writedata,
        .avs_byteenable, .avs_readdata, .avs_waitrequest, .timer_tick, .timer_one_carry,
        .timer_three_count, .capture_event, .pwm_level, .portb_direction_register, .portb_data,
        .portb_bit2_pwm_one_pin, .portb_bit3_pwm_two_pin, .pwm_one_enable, .pwm_two_enable,
        .timer_run, .timer_inc, .timer_pair_wide_select, .period_active, .period_value);
    // ****************
    // shared tasks
    // ****************
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // one avalon transfer, held until waitrequest low, then one idle edge
    task automatic bus(input logic wr, input logic [5:0] idx, input logic [7:0] wd, output logic [7:0] rd);
        int n;
        n = 0;
        avs_address <= {idx, 2'b00};
        avs_writedata <= {24'h0, wd};
        avs_write <= wr;
        avs_read <= !wr;
        do begin
            @(posedge core_clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 20);
        rd = avs_readdata[7:0];
        if (n == 20) check("bus timeout", 1, 0);
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        @(posedge core_clk);
    endtask
    task automatic wr(input logic [5:0] idx, input logic [7:0] d);
        logic [7:0] junk;
        bus(1'b1, idx, d, junk);
    endtask
    task automatic rdchk(input logic [5:0] idx, input logic [7:0] exp, input string what);
        logic [7:0] d;
        bus(1'b0, idx, 8'h00, d);
        check(what, d, exp);
    endtask
    // one-cycle capture pulse on the chosen channels
    task automatic cap(input logic [1:0] ch, input tpc_word_t v);
        timer_three_count <= v;
        capture_event <= ch;
        @(posedge core_clk);
        capture_event <= 2'h0;
        @(posedge core_clk);
    endtask
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    // ****************
    // scenarios
    // ****************
    task automatic t_access;
        rdchk(`TPC_IDX_CTRL_TWO, 8'h00, "ctrl two reset");
        check("pins reset", {portb_bit2_pwm_one_pin, portb_bit3_pwm_two_pin}, 4'h5);
        wr(`TPC_IDX_CTRL_TWO, 8'hff);
        rdchk(`TPC_IDX_CTRL_TWO, 8'h3f, "flags read only");
        check("pwm enables", {pwm_two_enable, pwm_one_enable}, 2'h3);
        check("run all", timer_run, 3'h7);
        rdchk(6'h00, 8'h00, "unmapped");
        wr(`TPC_IDX_CTRL_TWO, 8'h00);
        check("stop all", timer_run, 3'h0);
        $display("test access done");
    endtask
    task automatic t_pins;
        logic [3:0] k;
        logic [1:0] e;
        for (int i = 0; i < 16; i++) begin
            k = i[3:0];
            wr(`TPC_IDX_CTRL_TWO, {2'h0, {2{k[0]}}, 4'h0});
            portb_direction_register <= {2{k[1]}};
            portb_data <= {2{k[2]}};
            pwm_level <= {2{k[3]}};
            repeat (2) @(posedge core_clk);
            e = k[0] ? {k[3], 1'b1} : {k[2], !k[1]};
            check("pin2", portb_bit2_pwm_one_pin, e);
            check("pin3", portb_bit3_pwm_two_pin, e);
        end
        $display("test pins done");
    endtask
    task automatic t_wide;
        wr(`TPC_IDX_CTRL_ONE, 8'h08);
        check("wide select", timer_pair_wide_select, 1'b1);
        rdchk(`TPC_IDX_CTRL_ONE, 8'h08, "ctrl one");
        wr(`TPC_IDX_CTRL_TWO, 8'h02);
        check("pair upper alone", timer_run, 3'h0);
        wr(`TPC_IDX_CTRL_TWO, 8'h07);
        check("pair run", timer_run, 3'h7);
        timer_tick <= 1'b1;
        @(posedge core_clk);
        check("no carry", timer_inc, 3'h5);
        timer_one_carry <= 1'b1;
        @(posedge core_clk);
        check("carry", timer_inc, 3'h7);
        timer_one_carry <= 1'b0;
        wr(`TPC_IDX_CTRL_ONE, 8'h00);
        check("narrow", timer_inc, 3'h7);
        timer_tick <= 1'b0;
        wr(`TPC_IDX_CTRL_TWO, 8'h00);
        $display("test wide done");
    endtask
    task automatic t_capture;
        wr(`TPC_IDX_CTRL_TWO, 8'h08);
        check("capture mode", period_active, 1'b0);
        cap(2'h3, 16'h1234);
        rdchk(`TPC_IDX_CTRL_TWO, 8'h08, "no overrun");
        rdchk(`TPC_IDX_CAP1_LO, 8'h34, "cap lo");
        rdchk(`TPC_IDX_CAP1_HI, 8'h12, "cap hi");
        cap(2'h3, 16'h5555);
        cap(2'h1, 16'h6666);
        rdchk(`TPC_IDX_CTRL_TWO, 8'hc8, "both overrun");
        check("kept", period_value, 16'h5555);
        rdchk(`TPC_IDX_CAP1_HI, 8'h55, "kept hi");
        rdchk(`TPC_IDX_CAP1_LO, 8'h55, "kept lo");
        rdchk(`TPC_IDX_CTRL_TWO, 8'h88, "overrun cleared");
        cap(2'h1, 16'h7777);
        check("reload", period_value, 16'h7777);
        wr(`TPC_IDX_CTRL_TWO, 8'h00);
        wr(`TPC_IDX_CAP1_LO, 8'hab);
        cap(2'h1, 16'h9999);
        check("period mode", {period_active, period_value[7:0]}, 9'h1ab);
        $display("test capture done");
    endtask
    // ****************
    // main sequence and watchdog
    // ****************
    initial begin
        repeat (16) @(posedge core_clk);
        sys_rst <= 1'b0;
        @(posedge core_clk);
        t_access;
        t_pins;
        t_wide;
        t_capture;
        tally_and_finish;
    end
    initial begin
        #100000;
        fail_count++;
        tally_and_finish;
    end
endmodule
